/* pkg/aqst_consts.svh */
// Purpose: constants of the converter queue status tracker
// Assumes: one 50 MHz converter clock, AXI4-Lite register access
// Notes:   register indices are word indices, byte address = index * 4
// Summary of operation
// - four-bit read-only code shows both queue states jointly, queue 1 on top
// - queue 1 idle: 0000..0011 for queue 2 idle, paused, active, pending
// - queue 1 paused: 0100..0111 for queue 2 idle, paused, active, pending
// - queue 1 active: 1000..1011; codes 1100..1111 are never produced
// - an idle queue executes nothing, is not paused, has no trigger
// - disabled or untriggered queue reads idle
// - never both queues active; trigger in valid mode makes a queue active
// - entry with pause bit leaves its queue paused until the next trigger
// - queue 1 trigger aborts queue 2, suspends it; resumes when queue 1 leaves
// - queue 2 trigger during queue 1 activity makes queue 2 trigger pending
// - pending queue 2 stays pending some clocks after queue 1 leaves
// - stop mode returns the code to both queues idle
// - debug freeze keeps the code unchanged
// - read-only six-bit command pointer names executing or last entry
// - on pause the pointer holds the pause entry until any trigger
// - pointer is updated clocks before the new queue shows active
// - scan ending on end-of-queue code leaves pointer on that entry
// - running past entry 63 ends the queue with the pointer at 0
// - queue 1 ending at queue 2 begin leaves pointer at that begin
// - stop mode clears the command pointer
// - debug freeze keeps the command pointer
// - last pointers at 13:8 and 5:0, reset 3f3f, writes ignored okay
// - software modes: pause bit retriggers after two clocks, no pause
// - stop sets both last pointers to 63; freeze keeps them
`ifndef AQST_CONSTS_SVH
`define AQST_CONSTS_SVH
`define AQST_IDX_STAT  32'h00ca0010
`define AQST_IDX_LAST  32'h00ca0012
`define AQST_IDX_CTRL  32'h00ca0014
`define AQST_LAST_RST  16'h3f3f
`define AQST_CTRL_RST  4'h3
`define AQST_CTRL_EN1  0
`define AQST_CTRL_EN2  1
`define AQST_CTRL_SW1  2
`define AQST_CTRL_SW2  3
`define AQST_PTR_MAX   6'h3f
`define AQST_END_CODE  6'h3f
`define AQST_Q1_BEGIN  6'h00
`define AQST_HAND_CLKS 2'h3
`define AQST_RTG_CLKS  2'h2
`define AQST_ST_IDLE   2'h0
`define AQST_ST_PAUSE  2'h1
`define AQST_ST_RUN    2'h2
`define AQST_ST_PEND   2'h3
`define AQST_RESP_OK   2'h0
`define AQST_RESP_DEC  2'h3
`endif

/* pkg/aqst_pkg.sv */
// Purpose: types of the converter queue status tracker
// Assumes: none
// Notes:   suspended and pending apply to queue 2 only
package aqst_pkg;
    typedef enum logic [2:0] {
        Q_IDLE,
        Q_ACT,
        Q_PAUSE,
        Q_SUSP,
        Q_PEND
    } aqst_qstate_t;
endpackage : aqst_pkg

/* hdl/aqst_tracker.sv */
// Purpose: queue state code, command pointer and last pointers
// Assumes: entry fields and conversion done come from same-clock logic
// Notes:   entry fields describe the entry at o_command_pointer
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "aqst_consts.svh"
module aqst_tracker
    import aqst_pkg::*;
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // axi4-lite write
    input  wire logic [31:0] i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    // axi4-lite read
    input  wire logic [31:0] i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    // converter sequencing
    input  wire logic        i_q1_trig,
    input  wire logic        i_q2_trig,
    input  wire logic [5:0]  i_q2_begin,
    input  wire logic [5:0]  i_entry_chan,
    input  wire logic        i_entry_pause,
    input  wire logic        i_conv_done,
    input  wire logic        i_stop,
    input  wire logic        i_freeze,
    // status out
    output logic             o_conv_req,
    output logic             o_conv_queue2,
    output logic             o_conv_abort,
    output logic [5:0]       o_command_pointer,
    output logic [3:0]       o_queue_state_code
);

    localparam logic [31:0] A_STAT = `AQST_IDX_STAT << 2;
    localparam logic [31:0] A_LAST = `AQST_IDX_LAST << 2;
    localparam logic [31:0] A_CTRL = `AQST_IDX_CTRL << 2;
    localparam logic [15:0] LAST_RST = `AQST_LAST_RST;

    ////////////////////////////////////////////////////////////////////
    // queue state
    aqst_qstate_t q1_r, q1_nxt, q2_r, q2_nxt;
    logic [5:0]   ptr_r, ptr_nxt;
    logic [5:0]   q1n_r, q1n_nxt, q2n_r, q2n_nxt;
    logic [5:0]   l1_r, l1_nxt, l2_r, l2_nxt;
    logic [1:0]   hnd_r, hnd_nxt, rtg_r, rtg_nxt;
    logic [3:0]   st_r, st_nxt;
    logic         abort_r, abort_nxt;
    logic [3:0]   ctrl_r, ctrl_nxt;
    logic         exe, sel1, fin, pau, sw, en1, en2;
    logic [5:0]   start;

    function automatic logic [1:0] enc1(aqst_qstate_t s);
        if (s == Q_ACT)
            return `AQST_ST_RUN;
        else if (s == Q_PAUSE)
            return `AQST_ST_PAUSE;
        else
            return `AQST_ST_IDLE;
    endfunction : enc1

    function automatic logic [1:0] enc2(aqst_qstate_t s);
        if (s == Q_ACT || s == Q_SUSP)
            return `AQST_ST_RUN;
        else if (s == Q_PAUSE)
            return `AQST_ST_PAUSE;
        else if (s == Q_PEND)
            return `AQST_ST_PEND;
        else
            return `AQST_ST_IDLE;
    endfunction : enc2

    assign en1  = ctrl_r[`AQST_CTRL_EN1];
    assign en2  = ctrl_r[`AQST_CTRL_EN2];
    assign sel1 = (q1_r == Q_ACT);
    assign exe  = (sel1 || q2_r == Q_ACT) && rtg_r == 2'h0;
    assign sw   = sel1 ? ctrl_r[`AQST_CTRL_SW1] : ctrl_r[`AQST_CTRL_SW2];
    assign o_conv_req    = exe && i_entry_chan != `AQST_END_CODE
                           && !i_freeze && !i_stop;
    assign o_conv_queue2 = !sel1;

    always_comb begin
        q1_nxt    = q1_r;
        q2_nxt    = q2_r;
        ptr_nxt   = ptr_r;
        q1n_nxt   = q1n_r;
        q2n_nxt   = q2n_r;
        l1_nxt    = l1_r;
        l2_nxt    = l2_r;
        hnd_nxt   = hnd_r;
        rtg_nxt   = rtg_r;
        abort_nxt = 1'b0;
        fin       = 1'b0;
        pau       = 1'b0;
        start     = 6'h00;
        if (i_stop) begin
            q1_nxt  = Q_IDLE;
            q2_nxt  = Q_IDLE;
            ptr_nxt = 6'h00;
            q1n_nxt = 6'h00;
            q2n_nxt = 6'h00;
            l1_nxt  = LAST_RST[13:8];
            l2_nxt  = LAST_RST[5:0];
            hnd_nxt = 2'h0;
            rtg_nxt = 2'h0;
        end else if (!i_freeze) begin
            if (rtg_r != 2'h0)
                rtg_nxt = rtg_r - 2'h1;
            if (hnd_r != 2'h0) begin
                hnd_nxt = hnd_r - 2'h1;
                if (hnd_r == 2'h1 && q2_r == Q_PEND)
                    q2_nxt = Q_ACT;
            end
            if (exe) begin
                if (i_entry_chan == `AQST_END_CODE) begin
                    fin = 1'b1;
                end else if (i_conv_done) begin
                    if (sel1)
                        l1_nxt = ptr_r;
                    else
                        l2_nxt = ptr_r;
                    if (i_entry_pause && !sw
                        && ptr_r != `AQST_PTR_MAX) begin
                        pau = 1'b1;
                        if (sel1)
                            q1n_nxt = ptr_r + 6'h01;
                        else
                            q2n_nxt = ptr_r + 6'h01;
                    end else begin
                        if (i_entry_pause)
                            rtg_nxt = `AQST_RTG_CLKS;
                        if (ptr_r == `AQST_PTR_MAX) begin
                            ptr_nxt = 6'h00;
                            fin     = 1'b1;
                        end else if (sel1 &&
                                     ptr_r + 6'h01 == i_q2_begin) begin
                            ptr_nxt = i_q2_begin;
                            fin     = 1'b1;
                        end else begin
                            ptr_nxt = ptr_r + 6'h01;
                        end
                    end
                end
                if (fin || pau) begin
                    rtg_nxt = 2'h0;
                    if (sel1)
                        q1_nxt = fin ? Q_IDLE : Q_PAUSE;
                    else
                        q2_nxt = fin ? Q_IDLE : Q_PAUSE;
                end
            end
            if (!en1)
                q1_nxt = Q_IDLE;
            if (!en2)
                q2_nxt = Q_IDLE;
            if (sel1 && q1_nxt != Q_ACT) begin
                if (q2_nxt == Q_PEND) begin
                    ptr_nxt = q2n_r;
                    hnd_nxt = `AQST_HAND_CLKS;
                end else if (q2_nxt == Q_SUSP) begin
                    q2_nxt  = Q_ACT;
                    ptr_nxt = q2n_r;
                end
            end
            if (i_q1_trig && en1 && q1_nxt != Q_ACT) begin
                ptr_nxt = (q1_nxt == Q_PAUSE) ? q1n_r
                                              : `AQST_Q1_BEGIN;
                q1_nxt  = Q_ACT;
                hnd_nxt = 2'h0;
                if (q2_nxt == Q_ACT) begin
                    q2_nxt    = Q_SUSP;
                    abort_nxt = q2_r == Q_ACT && rtg_r == 2'h0;
                    q2n_nxt   = q2_r == Q_ACT ? ptr_r : q2n_r;
                    rtg_nxt   = 2'h0;
                end
            end
            if (i_q2_trig && en2 &&
                (q2_nxt == Q_IDLE || q2_nxt == Q_PAUSE)) begin
                start   = (q2_nxt == Q_PAUSE) ? q2n_nxt : i_q2_begin;
                q2n_nxt = start;
                if (q1_nxt == Q_ACT) begin
                    q2_nxt = Q_PEND;
                end else begin
                    q2_nxt  = Q_ACT;
                    ptr_nxt = start;
                end
            end
        end
        st_nxt = {enc1(q1_nxt), enc2(q2_nxt)};
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q1_r    <= Q_IDLE;
            q2_r    <= Q_IDLE;
            ptr_r   <= 6'h00;
            q1n_r   <= 6'h00;
            q2n_r   <= 6'h00;
            l1_r    <= LAST_RST[13:8];
            l2_r    <= LAST_RST[5:0];
            hnd_r   <= 2'h0;
            rtg_r   <= 2'h0;
            st_r    <= 4'h0;
            abort_r <= 1'b0;
        end else begin
            q1_r    <= q1_nxt;
            q2_r    <= q2_nxt;
            ptr_r   <= ptr_nxt;
            q1n_r   <= q1n_nxt;
            q2n_r   <= q2n_nxt;
            l1_r    <= l1_nxt;
            l2_r    <= l2_nxt;
            hnd_r   <= hnd_nxt;
            rtg_r   <= rtg_nxt;
            st_r    <= st_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign o_command_pointer  = ptr_r;
    assign o_queue_state_code = st_r;
    assign o_conv_abort       = abort_r;

    ////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic        awh_r, awh_nxt, wh_r, wh_nxt;
    logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
    logic        ws_r, ws_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;

    assign o_axi_awready = !awh_r;
    assign o_axi_wready  = !wh_r;
    assign o_axi_arready = !rv_r;
    assign o_axi_bvalid  = bv_r;
    assign o_axi_bresp   = br_r;
    assign o_axi_rvalid  = rv_r;
    assign o_axi_rresp   = rr_r;
    assign o_axi_rdata   = rd_r;

    always_comb begin
        awh_nxt  = awh_r;
        awa_nxt  = awa_r;
        wh_nxt   = wh_r;
        wd_nxt   = wd_r;
        ws_nxt   = ws_r;
        bv_nxt   = bv_r;
        br_nxt   = br_r;
        rv_nxt   = rv_r;
        rr_nxt   = rr_r;
        rd_nxt   = rd_r;
        ctrl_nxt = ctrl_r;
        if (i_axi_awvalid && !awh_r) begin
            awh_nxt = 1'b1;
            awa_nxt = i_axi_awaddr;
        end
        if (i_axi_wvalid && !wh_r) begin
            wh_nxt = 1'b1;
            wd_nxt = i_axi_wdata;
            ws_nxt = i_axi_wstrb[0];
        end
        if (bv_r && i_axi_bready)
            bv_nxt = 1'b0;
        if (awh_r && wh_r && !bv_r) begin
            awh_nxt = 1'b0;
            wh_nxt  = 1'b0;
            bv_nxt  = 1'b1;
            br_nxt  = `AQST_RESP_OK;
            if (awa_r == A_CTRL) begin
                if (ws_r)
                    ctrl_nxt = wd_r[3:0];
            end else if (awa_r == A_STAT || awa_r == A_LAST) begin
                br_nxt = `AQST_RESP_OK;
            end else begin
                br_nxt = `AQST_RESP_DEC;
            end
        end
        if (rv_r && i_axi_rready)
            rv_nxt = 1'b0;
        if (i_axi_arvalid && !rv_r) begin
            rv_nxt = 1'b1;
            rr_nxt = `AQST_RESP_OK;
            rd_nxt = 32'h0;
            if (i_axi_araddr == A_STAT)
                rd_nxt = {22'h0, st_r, ptr_r};
            else if (i_axi_araddr == A_LAST)
                rd_nxt = {18'h0, l1_r, 2'h0, l2_r};
            else if (i_axi_araddr == A_CTRL)
                rd_nxt = {28'h0, ctrl_r};
            else
                rr_nxt = `AQST_RESP_DEC;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            awh_r  <= 1'b0;
            awa_r  <= 32'h0;
            wh_r   <= 1'b0;
            wd_r   <= 32'h0;
            ws_r   <= 1'b0;
            bv_r   <= 1'b0;
            br_r   <= 2'h0;
            rv_r   <= 1'b0;
            rr_r   <= 2'h0;
            rd_r   <= 32'h0;
            ctrl_r <= `AQST_CTRL_RST;
        end else begin
            awh_r  <= awh_nxt;
            awa_r  <= awa_nxt;
            wh_r   <= wh_nxt;
            wd_r   <= wd_nxt;
            ws_r   <= ws_nxt;
            bv_r   <= bv_nxt;
            br_r   <= br_nxt;
            rv_r   <= rv_nxt;
            rr_r   <= rr_nxt;
            rd_r   <= rd_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst || i_stop || i_freeze);

    a_one_active: assert property (
        !(q1_r == Q_ACT && q2_r == Q_ACT))
        else $error("both queues active");
    a_code_range: assert property (
        o_queue_state_code[3:2] != 2'h3 &&
        (o_queue_state_code == {enc1(q1_r), enc2(q2_r)}))
        else $error("state code reserved or stale");
    a_susp_q1: assert property (
        q2_r == Q_SUSP |-> q1_r == Q_ACT)
        else $error("queue 2 suspended without queue 1");
    a_hand_delay: assert property (
        (q2_r == Q_PEND && q1_r != Q_ACT && hnd_r == 2'h3 &&
         !i_q1_trig && en2) ##1 (!i_q1_trig && en2)[*2]
        |=> q2_r == Q_ACT)
        else $error("pending handoff length wrong");
    a_hand_ptr: assert property (
        ($fell(q1_r == Q_ACT) && q2_r == Q_PEND)
        |-> ptr_r == q2n_r && q2_r == Q_PEND)
        else $error("pointer not loaded before handoff");
    a_stop_clear: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_stop |=> st_r == 4'h0 && ptr_r == 6'h00 &&
                   {2'h0, l1_r, 2'h0, l2_r} == `AQST_LAST_RST)
        else $error("stop did not clear state");
    a_frz_hold: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        (i_freeze && !i_stop) |=> $stable(st_r) && $stable(ptr_r)
                                  && $stable(l1_r) && $stable(l2_r))
        else $error("freeze changed state");
    a_idle_quiet: assert property (
        (q1_r == Q_IDLE && q2_r != Q_ACT) |-> !o_conv_req)
        else $error("conversion from idle queue");
    a_pause_hold: assert property (
        (o_conv_req && i_conv_done && i_entry_pause && !sw &&
         ptr_r != 6'h3f && !i_q1_trig && !i_q2_trig && en1 && en2
         && q2_r != Q_PEND)
        |=> (sel1 ? q1_r : q2_r) == Q_PAUSE && $stable(ptr_r)
        || q1_r == Q_PAUSE || q2_r == Q_PAUSE)
        else $error("pause entry did not pause");
    a_wrap_zero: assert property (
        (o_conv_req && i_conv_done && ptr_r == 6'h3f &&
         !i_q1_trig && !i_q2_trig && q2_r != Q_SUSP && q2_r != Q_PEND)
        |=> ptr_r == 6'h00)
        else $error("pointer did not wrap to zero");
    a_sw_retrig: assert property (
        (o_conv_req && i_conv_done && i_entry_pause && sw &&
         ptr_r != 6'h3f && !i_q1_trig && !i_q2_trig &&
         !(sel1 && ptr_r + 6'h01 == i_q2_begin))
        |=> rtg_r == 2'h2 && !o_conv_req ##1 rtg_r == 2'h1)
        else $error("software retrigger timing wrong");

    c_suspend: cover property (q2_r == Q_SUSP);
    c_handoff: cover property (hnd_r == 2'h1 && q2_r == Q_PEND);
    c_retrig:  cover property (rtg_r == 2'h2);
    c_wrap:    cover property ($past(ptr_r) == 6'h3f && ptr_r == 6'h00);

endmodule : aqst_tracker

/* testbench/aqst_tracker_bench.sv */
// Purpose: self-checking bench of the converter queue status tracker
// Assumes: bench answers conversions and holds the entry table itself
// Notes:   expected codes are written out per step as integer queue-state pairs
`timescale 1ns/1ns
`include "aqst_consts.svh"
module aqst_tracker_bench;
    import aqst_pkg::*;
    localparam int IDL = 0;
    localparam int PAU = 1;
    localparam int ACT = 2;
    localparam int PND = 3;
    localparam logic [31:0] A_STAT = `AQST_IDX_STAT << 2;
    localparam logic [31:0] A_LAST = `AQST_IDX_LAST << 2;
    localparam logic [31:0] A_CTRL = `AQST_IDX_CTRL << 2;
    logic        i_mclk    = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [31:0] awaddr    = '0;
    logic [31:0] wdata     = '0;
    logic [31:0] araddr    = '0;
    logic [31:0] rdata;
    logic [3:0]  wstrb     = 4'hf;
    logic        awvalid   = 1'b0;
    logic        wvalid    = 1'b0;
    logic        bready    = 1'b0;
    logic        arvalid   = 1'b0;
    logic        rready    = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        q1_trig   = 1'b0;
    logic        q2_trig   = 1'b0;
    logic [5:0]  q2_begin  = 6'h08;
    logic        conv_done = 1'b0;
    logic        stop      = 1'b0;
    logic        freeze    = 1'b0;
    logic [5:0]  entry_chan, cmd_ptr;
    logic        entry_pause, conv_req, conv_abort, conv_q2;
    logic [3:0]  st_code;
    logic [5:0]  tab_chan [64];
    logic        tab_pause [64];
    logic        done_en   = 1'b0;
    logic        req_seen  = 1'b0;
    logic        abort_seen = 1'b0;
    logic        q1_pause_seen = 1'b0;
    logic [31:0] lfsr_r    = 32'h979c;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #10 i_mclk = ~i_mclk;

    aqst_tracker i_aqst_tracker (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
        .o_axi_awready(awready), .i_axi_wdata(wdata),
        .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
        .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
        .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .i_q1_trig(q1_trig), .i_q2_trig(q2_trig), .i_q2_begin(q2_begin),
        .i_entry_chan(entry_chan), .i_entry_pause(entry_pause),
        .i_conv_done(conv_done), .i_stop(stop), .i_freeze(freeze),
        .o_conv_req(conv_req), .o_conv_queue2(conv_q2),
        .o_conv_abort(conv_abort),
        .o_command_pointer(cmd_ptr), .o_queue_state_code(st_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // converter side: entry table and conversion answers
    assign entry_chan  = tab_chan[cmd_ptr];
    assign entry_pause = tab_pause[cmd_ptr];
    always @(negedge i_mclk) begin
        req_seen <= done_en && conv_req && !conv_done;
        if (conv_abort === 1'b1) abort_seen <= 1'b1;
        if (st_code[3:2] === 2'b01) q1_pause_seen <= 1'b1;
        if (!i_sys_rst) note("reserved code", 32'h0,
                             {31'h0, st_code[3:2] == 2'b11});
    end
    always @(posedge i_mclk) conv_done <= req_seen;

    ////////////////////////////////////////////////////////////////////////
    // compare tasks
    task automatic note(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : note
    task automatic chk_bus(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        note(what, exp, got);
    endtask : chk_bus
    task automatic chk_code(input int q1, input int q2);
        note("state code", 32'(q1 * 4 + q2), {28'h0, st_code});
    endtask : chk_code
    task automatic chk_ptr(input logic [5:0] exp);
        note("command pointer", {26'h0, exp}, {26'h0, cmd_ptr});
    endtask : chk_ptr
    task automatic wait_code(input int q1, input int q2);
        for (int n = 0; n < 200 && st_code !== 4'(q1 * 4 + q2); n++) begin
            @(negedge i_mclk);
        end
        chk_code(q1, q2);
    endtask : wait_code

    ////////////////////////////////////////////////////////////////////////
    // stimulus tasks
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d,
                             output logic [1:0] resp);
        logic aw_hs, w_hs, b_hs;
        resp = 2'bxx;
        b_hs = 1'b0;
        @(posedge i_mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50 && !b_hs; n++) begin
            @(negedge i_mclk);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid && bready;
            if (b_hs) resp = bresp;
            @(posedge i_mclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
        end
        if (!b_hs) miscompares++;
    endtask : bus_write
    task automatic bus_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        logic ar_hs, r_hs;
        resp = 2'bxx;
        d = 'x;
        r_hs = 1'b0;
        @(posedge i_mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50 && !r_hs; n++) begin
            @(negedge i_mclk);
            ar_hs = arvalid && arready;
            r_hs  = rvalid && rready;
            if (r_hs) d = rdata;
            if (r_hs) resp = rresp;
            @(posedge i_mclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) rready <= 1'b0;
        end
        if (!r_hs) miscompares++;
    endtask : bus_read
    task automatic trig(input logic t1, input logic t2);
        @(posedge i_mclk);
        q1_trig <= t1;
        q2_trig <= t2;
        @(posedge i_mclk);
        q1_trig <= 1'b0;
        q2_trig <= 1'b0;
        @(negedge i_mclk);
    endtask : trig
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (6000) @(posedge i_mclk);
        miscompares++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        for (int i = 0; i < 64; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            tab_chan[i]  = {1'b0, lfsr_r[4:0]};
            tab_pause[i] = 1'b0;
        end
        tab_chan[11] = `AQST_END_CODE;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        bus_read(A_LAST, d, r);
        chk_bus("last pointers", {16'h0, `AQST_LAST_RST}, d);
        bus_write(A_LAST, lfsr_next(lfsr_r), r);
        chk_bus("write response", 32'h0, {30'h0, r});
        bus_write(A_STAT, 32'hffff_ffff, r);
        bus_read(A_LAST, d, r);
        chk_bus("last pointers", {16'h0, `AQST_LAST_RST}, d);
        bus_read(A_STAT, d, r);
        chk_bus("status", 32'h0, d);
        bus_read(32'h0328_0100, d, r);
        chk_bus("unmapped response", 32'h3, {30'h0, r});
        end_test("registers");
        // queue 2 scan ending on the end code at entry 11
        done_en = 1'b1;
        trig(1'b0, 1'b1);
        chk_code(IDL, ACT);
        chk_bus("request queue", 32'h1, {31'h0, conv_q2});
        wait_code(IDL, IDL);
        chk_ptr(6'd11);
        // queue 1 runs up to the queue 2 begin entry
        trig(1'b1, 1'b0);
        chk_code(ACT, IDL);
        chk_bus("request queue", 32'h0, {31'h0, conv_q2});
        wait_code(IDL, IDL);
        chk_ptr(6'd8);
        bus_read(A_LAST, d, r);
        chk_bus("last pointers", 32'h070a, d);
        // queue 2 wraps past entry 63
        q2_begin <= 6'd60;
        trig(1'b0, 1'b1);
        wait_code(IDL, IDL);
        chk_ptr(6'd0);
        q2_begin <= 6'd8;
        end_test("scan ends");
        // queue 1 preempts queue 2
        done_en = 1'b0;
        trig(1'b0, 1'b1);
        abort_seen = 1'b0;
        trig(1'b1, 1'b0);
        chk_code(ACT, ACT);
        @(negedge i_mclk);
        chk_bus("abort", 32'h1, {31'h0, abort_seen});
        done_en = 1'b1;
        wait_code(IDL, ACT);
        wait_code(IDL, IDL);
        end_test("suspend");
        // both triggers together: queue 2 goes pending, then hands over
        done_en = 1'b0;
        trig(1'b1, 1'b1);
        chk_code(ACT, PND);
        done_en = 1'b1;
        wait_code(IDL, PND);
        chk_ptr(6'd8);
        n = 1;
        for (int k = 0; k < 10 && st_code === 4'b0011; k++) begin
            @(negedge i_mclk);
            if (st_code === 4'b0011) n++;
        end
        chk_bus("pending clocks", {30'h0, `AQST_HAND_CLKS}, n);
        chk_code(IDL, ACT);
        wait_code(IDL, IDL);
        end_test("handoff");
        // pause entry in queue 1
        tab_pause[2] = 1'b1;
        trig(1'b1, 1'b0);
        wait_code(PAU, IDL);
        repeat (5) @(negedge i_mclk);
        chk_code(PAU, IDL);
        chk_ptr(6'd2);
        chk_bus("request", 32'h0, {31'h0, conv_req});
        trig(1'b0, 1'b1);
        chk_code(PAU, ACT);
        wait_code(PAU, IDL);
        trig(1'b1, 1'b0);
        wait_code(IDL, IDL);
        // software mode on queue 1 never pauses
        bus_write(A_CTRL, 32'h7, r);
        q1_pause_seen = 1'b0;
        trig(1'b1, 1'b0);
        wait_code(IDL, IDL);
        chk_bus("software pause", 32'h0, {31'h0, q1_pause_seen});
        tab_pause[2] = 1'b0;
        // disabled queue 2 ignores its trigger
        bus_write(A_CTRL, 32'h1, r);
        trig(1'b0, 1'b1);
        @(negedge i_mclk);
        chk_code(IDL, IDL);
        bus_write(A_CTRL, 32'h3, r);
        end_test("pause and modes");
        // freeze holds everything, stop clears it
        done_en = 1'b1;
        trig(1'b1, 1'b0);
        repeat (4) @(posedge i_mclk);
        freeze <= 1'b1;
        @(negedge i_mclk);
        d = {26'h0, cmd_ptr};
        trig(1'b0, 1'b1);
        repeat (4) @(negedge i_mclk);
        chk_code(ACT, IDL);
        chk_ptr(d[5:0]);
        @(posedge i_mclk);
        freeze <= 1'b0;
        stop   <= 1'b1;
        @(posedge i_mclk);
        stop   <= 1'b0;
        done_en = 1'b0;
        @(negedge i_mclk);
        chk_code(IDL, IDL);
        chk_ptr(6'd0);
        bus_read(A_LAST, d, r);
        chk_bus("last pointers", {16'h0, `AQST_LAST_RST}, d);
        end_test("freeze and stop");
        stop_test();
    end
endmodule : aqst_tracker_bench
